//--- rtl/cwf_pkg.sv
// shared constants and types of the transceiver mode and supervision logic
package cwf_pkg;

  typedef enum logic [1:0] {
    TRX_OFF    = 2'h0,
    TRX_WAKE   = 2'h1,
    TRX_NORMAL = 2'h2,
    TRX_RXONLY = 2'h3
  } cwf_trx_type;

  typedef enum logic [2:0] {
    SBC_NORMAL   = 3'h0,
    SBC_STOP     = 3'h1,
    SBC_SLEEP    = 3'h2,
    SBC_RESTART  = 3'h3,
    SBC_FAILSAFE = 3'h4
  } cwf_sbc_type;

  typedef enum logic [1:0] {
    WK_IDLE = 2'h0,
    WK_DOM1 = 2'h1,
    WK_REC  = 2'h2,
    WK_DOM2 = 2'h3
  } cwf_wake_type;

  localparam cwf_trx_type TRX_RESET = TRX_OFF;
  localparam cwf_sbc_type SBC_RESET = SBC_NORMAL;

  // timing, figures in their own unit
  localparam int unsigned CLK_MHZ     = 100;
  localparam int unsigned WAKE_MIN_NS = 500;
  localparam int unsigned WAKE_MAX_US = 1000;
  localparam int unsigned TXTO_US     = 2000;
  localparam int unsigned BUSTO_US    = 2000;
  localparam int unsigned TXEN_US     = 20;
  localparam int unsigned WAKE_MIN_CYC = (WAKE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WAKE_MAX_CYC = WAKE_MAX_US * CLK_MHZ;
  localparam int unsigned TXTO_CYC     = TXTO_US * CLK_MHZ;
  localparam int unsigned BUSTO_CYC    = BUSTO_US * CLK_MHZ;
  localparam int unsigned TXEN_CYC     = TXEN_US * CLK_MHZ;
  localparam int unsigned CNT_W        = 24;

  // register map of the controller
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_CLR  = 8'h08;
  localparam int CTRL_TRX = 0;
  localparam int CTRL_SBC = 2;
  localparam int CTRL_WD  = 5;
  localparam int CTRL_WWK = 6;
  localparam int CTRL_SUP = 7;
  localparam int ST_WD    = 5;
  localparam int ST_INT   = 6;
  localparam int ST_RX    = 7;
  localparam int ST_WAKE  = 8;
  localparam int ST_FAIL  = 9;
  localparam int ST_UV    = 10;
  localparam int ST_REJ   = 11;
  localparam int ST_TXTO  = 12;
  localparam int CLR_REJ  = 3;

endpackage

//--- rtl/cwf_if.sv
// link between the transceiver logic and its controller
`timescale 1ns/1ps
`default_nettype none
interface cwf_if;
  import cwf_pkg::*;
  cwf_trx_type trx_req;
  cwf_sbc_type sbc_req;
  logic        wd_en_req;
  logic        wd_wake_en;
  logic        cmd_wr;
  logic [2:0]  flag_clr;
  logic        transmit_line_in;
  cwf_trx_type trx_mode;
  cwf_sbc_type sbc_mode;
  logic        wd_en;
  logic        int_n;
  logic        receive_line_out;
  logic        bus_wake_flag;
  logic        bus_fail_flag;
  logic        supply_low_flag;
  logic        tx_timeout;

  modport dev (
    input  trx_req, sbc_req, wd_en_req, wd_wake_en, cmd_wr, flag_clr,
    input  transmit_line_in,
    output trx_mode, sbc_mode, wd_en, int_n, receive_line_out,
    output bus_wake_flag, bus_fail_flag, supply_low_flag, tx_timeout
  );
  modport ctl (
    output trx_req, sbc_req, wd_en_req, wd_wake_en, cmd_wr, flag_clr,
    output transmit_line_in,
    input  trx_mode, sbc_mode, wd_en, int_n, receive_line_out,
    input  bus_wake_flag, bus_fail_flag, supply_low_flag, tx_timeout
  );
endinterface
`default_nettype wire

//--- rtl/cwf_device.sv
// transceiver mode, wake detection and bus supervision of the device
`timescale 1ns/1ps
`default_nettype none
module cwf_device
  import cwf_pkg::*;
#(
  parameter int unsigned CW           = CNT_W,
  parameter int unsigned TXTO_LIM     = TXTO_CYC,
  parameter int unsigned BUSTO_LIM    = BUSTO_CYC,
  parameter int unsigned WAKE_MIN_LIM = WAKE_MIN_CYC,
  parameter int unsigned WAKE_MAX_LIM = WAKE_MAX_CYC
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  cwf_if.dev        link,
  input  wire logic bus_dom_in,
  input  wire logic supply_low_in,
  output logic      drv_dominant,
  output logic      drv_enable
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0]   sync1_r;
  logic [1:0]   sync2_r;
  logic         dom_q_r;
  logic         bus_dom;
  logic         sup_low;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= 2'h0;
      sync2_r <= 2'h0;
      dom_q_r <= 1'b0;
    end else begin
      sync1_r <= {supply_low_in, bus_dom_in};
      sync2_r <= sync1_r;
      dom_q_r <= sync2_r[0];
    end
  end
  assign bus_dom = sync2_r[0];
  assign sup_low = sync2_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // modes
  cwf_trx_type  trx_r;
  cwf_trx_type  trx_nxt;
  cwf_sbc_type  sbc_r;
  logic         wake_ev;
  logic         active;
  logic         norm;
  logic         rxmode;
  logic         armed_r;
  logic         woke_r;

  always_comb begin
    trx_nxt = trx_r;
    if (link.cmd_wr) begin
      trx_nxt = link.trx_req;
      if (link.sbc_req == SBC_FAILSAFE) begin
        trx_nxt = TRX_WAKE;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trx_r <= TRX_RESET;
    end else begin
      trx_r <= trx_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sbc_r <= SBC_RESET;
    end else if (wake_ev && (sbc_r == SBC_SLEEP || sbc_r == SBC_RESTART ||
                             sbc_r == SBC_FAILSAFE)) begin
      sbc_r <= SBC_RESTART;
    end else if (link.cmd_wr) begin
      sbc_r <= link.sbc_req;
    end
  end

  assign active = (sbc_r == SBC_NORMAL) || (sbc_r == SBC_STOP);
  assign norm   = active && (trx_r == TRX_NORMAL);
  assign rxmode = active && (trx_r == TRX_NORMAL || trx_r == TRX_RXONLY);

  // rearm beats a wake in the same cycle; the wake flag plays no part
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed_r <= 1'b0;
    end else if (trx_nxt == TRX_WAKE && trx_r != TRX_WAKE) begin
      armed_r <= 1'b1;
    end else if (link.cmd_wr && link.sbc_req != sbc_r &&
                 (link.sbc_req == SBC_STOP ||
                  link.sbc_req == SBC_FAILSAFE)) begin
      armed_r <= 1'b1;
    end else if (wake_ev) begin
      armed_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      woke_r <= 1'b0;
    end else if (trx_nxt != trx_r) begin
      woke_r <= 1'b0;
    end else if (wake_ev) begin
      woke_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake pattern filter
  cwf_wake_type wst_r;
  logic [CW-1:0] wcnt_r;
  logic         win_ok;
  logic         too_long;
  logic         wk_run;
  logic         wk_hit_r;

  assign wk_run   = (trx_r == TRX_WAKE) && armed_r;
  assign win_ok   = (wcnt_r > CW'(WAKE_MIN_LIM)) &&
                    (wcnt_r < CW'(WAKE_MAX_LIM));
  assign too_long = (wcnt_r >= CW'(WAKE_MAX_LIM));
  assign wake_ev  = wk_hit_r && wk_run;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wst_r    <= WK_IDLE;
      wcnt_r   <= '0;
      wk_hit_r <= 1'b0;
    end else begin
      wk_hit_r <= 1'b0;
      wcnt_r   <= (wcnt_r == '1) ? wcnt_r : wcnt_r + 1'b1;
      if (!wk_run) begin
        wst_r <= WK_IDLE;
      end else begin
        case (wst_r)
          WK_IDLE: begin
            if (bus_dom && !dom_q_r) begin
              wst_r  <= WK_DOM1;
              wcnt_r <= '0;
            end
          end
          WK_DOM1: begin
            if (too_long) begin
              wst_r <= WK_IDLE;
            end else if (!bus_dom) begin
              wst_r  <= win_ok ? WK_REC : WK_IDLE;
              wcnt_r <= '0;
            end
          end
          WK_REC: begin
            if (too_long) begin
              wst_r <= WK_IDLE;
            end else if (bus_dom) begin
              wst_r  <= win_ok ? WK_DOM2 : WK_DOM1;
              wcnt_r <= '0;
            end
          end
          WK_DOM2: begin
            if (too_long) begin
              wst_r <= WK_IDLE;
            end else if (!bus_dom) begin
              wk_hit_r <= win_ok;
              wst_r    <= WK_IDLE;
            end
          end
          default: wst_r <= WK_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake results; hardware set beats a clear in the same cycle
  logic wake_fl_r;
  logic int_n_r;
  logic wd_en_r;

  // interrupt kept active low in its own flop so the pin needs no inverter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_fl_r <= 1'b0;
      int_n_r   <= 1'b1;
    end else begin
      if (wake_ev) begin
        wake_fl_r <= 1'b1;
      end else if (link.flag_clr[0]) begin
        wake_fl_r <= 1'b0;
      end
      if (wake_ev && active) begin
        int_n_r <= 1'b0;
      end else if (link.flag_clr[0]) begin
        int_n_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_en_r <= 1'b0;
    end else if (wake_ev && sbc_r == SBC_STOP && link.wd_wake_en) begin
      wd_en_r <= 1'b1;
    end else if (link.cmd_wr) begin
      wd_en_r <= link.wd_en_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit time-out, bus clamp, supply undervoltage
  logic [CW-1:0] txcnt_r;
  logic [CW-1:0] buscnt_r;
  logic          txto_r;
  logic          uv_r;
  logic          fail_fl_r;
  logic          uv_fl_r;
  logic          tx_dom;
  logic          txto_set;
  logic          clamp_set;
  logic          uv_now;

  assign tx_dom    = !link.transmit_line_in;
  assign txto_set  = norm && tx_dom && (txcnt_r == CW'(TXTO_LIM));
  assign clamp_set = rxmode && bus_dom && (buscnt_r == CW'(BUSTO_LIM));
  assign uv_now    = rxmode && sup_low;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txcnt_r  <= '0;
      buscnt_r <= '0;
    end else begin
      if (norm && tx_dom) begin
        txcnt_r <= (txcnt_r == '1) ? txcnt_r : txcnt_r + 1'b1;
      end else begin
        txcnt_r <= '0;
      end
      if (rxmode && bus_dom) begin
        buscnt_r <= (buscnt_r == '1) ? buscnt_r : buscnt_r + 1'b1;
      end else begin
        buscnt_r <= '0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txto_r <= 1'b0;
      uv_r   <= 1'b0;
    end else begin
      if (!norm || !tx_dom) begin
        txto_r <= 1'b0;
      end else if (txto_set) begin
        txto_r <= 1'b1;
      end
      uv_r <= uv_now;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fail_fl_r <= 1'b0;
      uv_fl_r   <= 1'b0;
    end else begin
      if (txto_set || clamp_set) begin
        fail_fl_r <= 1'b1;
      end else if (link.flag_clr[1]) begin
        fail_fl_r <= 1'b0;
      end
      if (uv_now && !uv_r) begin
        uv_fl_r <= 1'b1;
      end else if (link.flag_clr[2]) begin
        uv_fl_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs; driver gating drops in the same cycle as the time-out
  logic rx_r;
  logic drv_en_r;
  logic drv_dom_r;
  logic drv_ok;

  assign drv_ok = norm && !txto_r && !uv_r && !txto_set;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_r      <= 1'b1;
      drv_en_r  <= 1'b0;
      drv_dom_r <= 1'b0;
    end else begin
      drv_en_r  <= drv_ok;
      drv_dom_r <= drv_ok && tx_dom;
      case (trx_r)
        TRX_WAKE: rx_r <= !woke_r;
        TRX_NORMAL,
        TRX_RXONLY: rx_r <= !(active && bus_dom);
        default: rx_r <= 1'b1;
      endcase
    end
  end

  assign drv_enable            = drv_en_r;
  assign drv_dominant          = drv_dom_r;
  assign link.receive_line_out = rx_r;
  assign link.trx_mode         = trx_r;
  assign link.sbc_mode         = sbc_r;
  assign link.wd_en            = wd_en_r;
  assign link.int_n            = int_n_r;
  assign link.bus_wake_flag    = wake_fl_r;
  assign link.bus_fail_flag    = fail_fl_r;
  assign link.supply_low_flag  = uv_fl_r;
  assign link.tx_timeout       = txto_r;

endmodule
`default_nettype wire

//--- rtl/cwf_ctl.sv
// controller end: AHB-Lite registers driving the transceiver link
`timescale 1ns/1ps
`default_nettype none
module cwf_ctl
  import cwf_pkg::*;
#(
  parameter int unsigned CW      = CNT_W,
  parameter int unsigned TXEN_LIM = TXEN_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic        hwrite,
  input  wire logic [1:0]  htrans,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  cwf_if.ctl               link,
  input  wire logic        can_tx_in,
  output logic             can_rx_out,
  output logic             int_n_out,
  output logic             supply_on,
  output logic             wdog_en_out
);

  ////////////////////////////////////////////////////////////////////////////
  // bus slave, zero wait states
  logic        ap_wr_r;
  logic [7:0]  ap_addr_r;
  logic [31:0] rdata_r;
  logic        hrdy_r;
  logic        take;
  logic [31:0] stat;
  cwf_trx_type trx_r;
  cwf_sbc_type sbc_r;
  logic        wd_r;
  logic        wwk_r;
  logic        sup_r;

  assign take = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_r   <= 1'b0;
      ap_addr_r <= 8'h00;
      rdata_r   <= 32'h0000_0000;
      hrdy_r    <= 1'b0;
    end else begin
      hrdy_r    <= 1'b1;
      ap_wr_r   <= take && hwrite;
      ap_addr_r <= haddr[7:0];
      rdata_r   <= 32'h0000_0000;
      if (take && !hwrite) begin
        if (haddr[7:0] == REG_CTRL) begin
          rdata_r <= {24'h000000, sup_r, wwk_r, wd_r, sbc_r, trx_r};
        end else if (haddr[7:0] == REG_STAT) begin
          rdata_r <= stat;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register and command strobes
  logic        cmd_r;
  logic        rej_r;
  logic [2:0]  clr_r;
  cwf_trx_type w_trx;
  logic [2:0]  w_sbc;
  logic        w_ok;

  assign w_trx = cwf_trx_type'(hwdata[CTRL_TRX +: 2]);
  assign w_sbc = hwdata[CTRL_SBC +: 3];
  // refused writes leave the register alone and raise the reject bit
  assign w_ok = (w_sbc <= 3'(SBC_FAILSAFE)) &&
                !(w_sbc == 3'(SBC_SLEEP) &&
                  (w_trx == TRX_NORMAL || w_trx == TRX_RXONLY)) &&
                !(link.trx_mode == TRX_WAKE && w_trx == TRX_NORMAL &&
                  !sup_r);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trx_r <= TRX_RESET;
      sbc_r <= SBC_RESET;
      wd_r  <= 1'b0;
      wwk_r <= 1'b0;
      sup_r <= 1'b0;
      cmd_r <= 1'b0;
      rej_r <= 1'b0;
      clr_r <= 3'h0;
    end else begin
      cmd_r <= 1'b0;
      clr_r <= 3'h0;
      if (ap_wr_r && ap_addr_r == REG_CTRL) begin
        if (w_ok) begin
          trx_r <= w_trx;
          sbc_r <= cwf_sbc_type'(w_sbc);
          wd_r  <= hwdata[CTRL_WD];
          wwk_r <= hwdata[CTRL_WWK];
          sup_r <= hwdata[CTRL_SUP];
          cmd_r <= 1'b1;
        end else begin
          rej_r <= 1'b1;
        end
      end else if (ap_wr_r && ap_addr_r == REG_CLR) begin
        clr_r <= hwdata[2:0];
        if (hwdata[CLR_REJ]) begin
          rej_r <= 1'b0;
        end
      end
    end
  end

  assign stat = {19'h00000, link.tx_timeout, rej_r, link.supply_low_flag,
                 link.bus_fail_flag, link.bus_wake_flag,
                 link.receive_line_out, link.int_n, link.wd_en,
                 link.sbc_mode, link.trx_mode};

  ////////////////////////////////////////////////////////////////////////////
  // transmit gating after the transceiver enters normal mode
  logic [CW-1:0] en_cnt_r;
  logic          gate_r;
  logic          tx_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_cnt_r <= '0;
      gate_r   <= 1'b0;
      tx_r     <= 1'b1;
    end else begin
      if (link.trx_mode != TRX_NORMAL) begin
        en_cnt_r <= '0;
        gate_r   <= 1'b0;
      end else if (en_cnt_r < CW'(TXEN_LIM)) begin
        en_cnt_r <= en_cnt_r + 1'b1;
      end else if (can_tx_in) begin
        gate_r <= 1'b1;
      end
      tx_r <= gate_r ? can_tx_in : 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // user side outputs
  logic rx_o_r;
  logic int_o_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_o_r  <= 1'b1;
      int_o_r <= 1'b1;
    end else begin
      rx_o_r  <= link.receive_line_out;
      int_o_r <= link.int_n;
    end
  end

  assign hreadyout             = hrdy_r;
  assign hresp                 = 1'b0;
  assign hrdata                = rdata_r;
  assign can_rx_out            = rx_o_r;
  assign int_n_out             = int_o_r;
  assign supply_on             = sup_r;
  assign wdog_en_out           = wd_r;
  assign link.trx_req          = trx_r;
  assign link.sbc_req          = sbc_r;
  assign link.wd_en_req        = wd_r;
  assign link.wd_wake_en       = wwk_r;
  assign link.cmd_wr           = cmd_r;
  assign link.flag_clr         = clr_r;
  assign link.transmit_line_in = tx_r;

endmodule
`default_nettype wire

//--- tb/cwf_link_chk.sv
// concurrent checks on the transceiver link signals
`timescale 1ns/1ps
`default_nettype none
module cwf_link_chk
  import cwf_pkg::*;
#(
  parameter int unsigned TXTO_LIM = 50
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire cwf_trx_type trx_req,
  input wire cwf_sbc_type sbc_req,
  input wire logic        cmd_wr,
  input wire logic        wd_wake_en,
  input wire logic        transmit_line_in,
  input wire cwf_trx_type trx_mode,
  input wire cwf_sbc_type sbc_mode,
  input wire logic        wd_en,
  input wire logic        int_n,
  input wire logic        receive_line_out,
  input wire logic        bus_wake_flag,
  input wire logic        bus_fail_flag,
  input wire logic        tx_timeout
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  int unsigned tx_cnt_r;
  ////////////////////////////////////////
  // consecutive dominant transmit cycles while the time-out is armed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_cnt_r <= 0;
    end else if (!transmit_line_in && trx_mode == TRX_NORMAL &&
                 sbc_mode inside {SBC_NORMAL, SBC_STOP}) begin
      tx_cnt_r <= tx_cnt_r + 1;
    end else begin
      tx_cnt_r <= 0;
    end
  end
  ////////////////////////////////////////
  a_wake_rx_low: assert property (
    $rose(bus_wake_flag) |-> ##[0:1] !receive_line_out)
    else $error("receive line not low after wake");
  // window kept short: a later mode toggle may legally release it
  a_rx_hold_low: assert property (
    $rose(bus_wake_flag) ##1 !receive_line_out
    |=> (!receive_line_out || trx_mode != TRX_WAKE) [*8])
    else $error("receive line released in wake mode");
  a_wake_int: assert property (
    $rose(bus_wake_flag) && sbc_mode inside {SBC_NORMAL, SBC_STOP}
    |-> ##[0:1] !int_n)
    else $error("no interrupt on wake");
  a_sleep_restart: assert property (
    $rose(bus_wake_flag) &&
    $past(sbc_mode) inside {SBC_SLEEP, SBC_RESTART, SBC_FAILSAFE}
    |-> sbc_mode == SBC_RESTART ##1 int_n)
    else $error("wake from low power not to restart");
  a_stop_stays: assert property (
    $rose(bus_wake_flag) && $past(sbc_mode) == SBC_STOP
    |-> sbc_mode == SBC_STOP)
    else $error("stop mode left on wake");
  a_stop_wdog: assert property (
    $rose(bus_wake_flag) && $past(sbc_mode) == SBC_STOP && wd_wake_en
    |-> ##[0:1] wd_en)
    else $error("watchdog not enabled on stop wake");
  a_cmd_modes: assert property (
    cmd_wr && sbc_req != SBC_FAILSAFE
    |=> trx_mode == $past(trx_req) && sbc_mode == $past(sbc_req))
    else $error("command not loaded");
  a_fs_rearm: assert property (
    cmd_wr && sbc_req == SBC_FAILSAFE
    |=> trx_mode == TRX_WAKE && sbc_mode == SBC_FAILSAFE)
    else $error("fail-safe not wake capable");
  a_txto_set: assert property (
    tx_cnt_r > TXTO_LIM + 2 |-> tx_timeout && bus_fail_flag)
    else $error("transmit time-out missed");
  a_txto_early: assert property (
    $rose(tx_timeout) |-> tx_cnt_r >= TXTO_LIM)
    else $error("transmit time-out too early");
  a_txto_clear: assert property (
    tx_timeout && transmit_line_in
    |-> ##[1:3] (!tx_timeout && trx_mode == TRX_NORMAL))
    else $error("transmit time-out not cleared");
  c_wake: cover property ($rose(bus_wake_flag));
  c_txto: cover property ($rose(tx_timeout));
  c_fail: cover property ($rose(bus_fail_flag));
endmodule
`default_nettype wire

//--- tb/test_can_wake_fault_control.sv
// bench joining both ends of the transceiver link
`timescale 1ns/1ps
`default_nettype none
module test_can_wake_fault_control;
  import cwf_pkg::*;
  localparam int unsigned TXTO = 50;
  // control word, expected mode bits of status
  localparam logic [31:0] ROWS [6][2] = '{'{32'h87, 32'h07},
    '{32'h82, 32'h02}, '{32'h89, 32'h09}, '{32'h8C, 32'h0C},
    '{32'h90, 32'h11}, '{32'h83, 32'h03}};
  localparam logic [31:0] LOWP [3] = '{32'h89, 32'h8D, 32'h90};
  logic        hclk          = 1'b0;
  logic        hresetn       = 1'b0;
  logic        hsel          = 1'b1;
  logic [2:0]  hsize         = 3'h2;
  logic [31:0] haddr         = 32'h0;
  logic        hwrite        = 1'b0;
  logic [1:0]  htrans        = 2'h0;
  logic [31:0] hwdata        = 32'h0;
  logic        bus_dom_in    = 1'b0;
  logic        supply_low_in = 1'b0;
  logic        can_tx_in     = 1'b1;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        can_rx_out;
  logic        int_n_out;
  logic        drv_dominant;
  logic        drv_enable;
  logic        supply_on;
  logic        wdog_en_out;
  logic [31:0] rd;
  int          num_errors    = 0;
  int          compares      = 0;
  always #5 hclk = ~hclk;
  cwf_if link ();
  cwf_device #(.TXTO_LIM(TXTO), .BUSTO_LIM(50), .WAKE_MIN_LIM(4),
    .WAKE_MAX_LIM(40)) u_cwf_device (.hclk(hclk), .hresetn(hresetn),
    .link(link), .bus_dom_in(bus_dom_in), .supply_low_in(supply_low_in),
    .drv_dominant(drv_dominant), .drv_enable(drv_enable));
  cwf_ctl #(.TXEN_LIM(10)) u_cwf_ctl (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .hwrite(hwrite), .htrans(htrans),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(link),
    .can_tx_in(can_tx_in), .can_rx_out(can_rx_out),
    .int_n_out(int_n_out), .supply_on(supply_on),
    .wdog_en_out(wdog_en_out));
  cwf_link_chk #(.TXTO_LIM(TXTO)) u_cwf_link_chk (.hclk(hclk),
    .hresetn(hresetn), .trx_req(link.trx_req), .sbc_req(link.sbc_req),
    .cmd_wr(link.cmd_wr), .wd_wake_en(link.wd_wake_en),
    .transmit_line_in(link.transmit_line_in), .trx_mode(link.trx_mode),
    .sbc_mode(link.sbc_mode), .wd_en(link.wd_en), .int_n(link.int_n),
    .receive_line_out(link.receive_line_out),
    .bus_wake_flag(link.bus_wake_flag),
    .bus_fail_flag(link.bus_fail_flag), .tx_timeout(link.tx_timeout));
  ////////////////////////////////////////
  task automatic results();
    if (num_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk_w(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_b(input string nm, input logic e, input logic g);
    chk_w(nm, {31'h0, e}, {31'h0, g});
  endtask
  // entered just after a rising edge; read data taken at the last edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic stat(input logic [31:0] m, input logic [31:0] e);
    // modes and flags settle one cycle after a command or clear pulse
    @(posedge hclk);
    bus(1'b0, REG_STAT, 32'h0);
    chk_w("stat", e, rd & m);
  endtask
  // dominant, recessive, dominant, each n cycles, then recessive
  task automatic wake_pattern(input int n);
    for (int i = 0; i < 4; i++) begin
      bus_dom_in <= !i[0];
      repeat (n) @(posedge hclk);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    stat(32'h1FFF, 32'h00C0);
    wake_pattern(10);
    stat(32'h1FF, 32'h0C0);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, REG_CTRL, ROWS[i][0]);
      stat(32'h1F, ROWS[i][1]);
    end
    bus(1'b1, REG_CTRL, 32'hC5);
    wake_pattern(2);
    stat(32'h100, 32'h0);
    wake_pattern(10);
    stat(32'h1FF, 32'h125);
    bus(1'b1, REG_CTRL, 32'h87);
    bus(1'b1, REG_CTRL, 32'h81);
    wake_pattern(10);
    stat(32'h1FF, 32'h101);
    chk_b("int_n_out", 1'b0, int_n_out);
    chk_b("can_rx_out", 1'b0, can_rx_out);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, REG_CLR, 32'h1);
      bus(1'b1, REG_CTRL, 32'h83);
      bus(1'b1, REG_CTRL, LOWP[i]);
      wake_pattern(10);
      stat(32'h1FF, 32'h14D);
    end
    bus(1'b1, REG_CLR, 32'hF);
    bus(1'b1, REG_CTRL, 32'h82);
    repeat (20) @(posedge hclk);
    can_tx_in <= 1'b0;
    repeat (10) @(posedge hclk);
    chk_b("drv_dominant", 1'b1, drv_dominant);
    repeat (TXTO + 5) @(posedge hclk);
    chk_b("drv_enable", 1'b0, drv_enable);
    stat(32'h1203, 32'h1202);
    can_tx_in <= 1'b1;
    repeat (5) @(posedge hclk);
    chk_b("drv_enable", 1'b1, drv_enable);
    stat(32'h1003, 32'h0002);
    bus(1'b1, REG_CLR, 32'h2);
    bus_dom_in <= 1'b1;
    repeat (TXTO + 10) @(posedge hclk);
    stat(32'h203, 32'h202);
    bus_dom_in <= 1'b0;
    supply_low_in <= 1'b1;
    repeat (5) @(posedge hclk);
    chk_b("drv_enable", 1'b0, drv_enable);
    stat(32'h403, 32'h402);
    supply_low_in <= 1'b0;
    repeat (5) @(posedge hclk);
    chk_b("drv_enable", 1'b1, drv_enable);
    stat(32'h3, 32'h2);
    bus(1'b1, REG_CTRL, 32'h8A);
    stat(32'h81F, 32'h802);
    bus(1'b1, REG_CLR, 32'h8);
    bus(1'b1, REG_CTRL, 32'h01);
    bus(1'b1, REG_CTRL, 32'h02);
    stat(32'h803, 32'h801);
    bus(1'b1, REG_CTRL, 32'hA0);
    @(posedge hclk);
    chk_b("wdog_en_out", 1'b1, wdog_en_out);
    chk_b("supply_on", 1'b1, supply_on);
    hsel <= 1'b0;
    bus(1'b1, REG_CTRL, 32'h83);
    hsel <= 1'b1;
    stat(32'h3F, 32'h20);
    bus(1'b1, 8'h10, 32'hFFFF_FFFF);
    bus(1'b0, 8'h10, 32'h0);
    chk_w("unmapped", 32'h0, rd);
    chk_b("hresp", 1'b0, hresp);
    results();
  end
  // the sequence needs a few hundred cycles
  initial begin
    #100000;
    num_errors++;
    results();
  end
endmodule
`default_nettype wire
